// ==== rtl/misc_ctrl_pkg.sv ====
// Purpose: constants and carrier types for the misc control bank
// Assumes: 10 MHz system clock, Avalon-MM word addressing
// Notes: register offsets are word indices
package misc_ctrl_pkg;
  // register word indices
  localparam logic [15:0] SERIAL_CLOCK_DIVIDER_CONTROL_IDX = 16'hf09e;
  localparam logic [15:0] BAUD_PARITY_CLOCK_CONTROL_IDX = 16'hf0c0;
  localparam logic [15:0] AUDIO_SWAP_TEST_CONTROL_IDX = 16'hf0c1;
  localparam logic [15:0] HOST_BUFFER_MODE_CONTROL_IDX = 16'hf0fd;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // baud_parity_clock_control fields
  localparam int BPC_RATE_LSB = 0;
  localparam int BPC_Q_INV = 3;
  localparam int BPC_SUB_INV = 4;
  localparam int BPC_EVEN = 5;
  localparam int BPC_LOCK = 6;
  localparam int BPC_DOUBLER = 7;
  localparam logic [7:0] BPC_WMASK = 8'hbb;
  // serial_clock_divider_control fields
  localparam int SCD_DIV_LSB = 0;
  localparam int SCD_SAMPLING = 6;
  localparam int SCD_SOURCE = 7;
  localparam logic [7:0] SCD_WMASK = 8'hff;
  // audio_swap_test_control fields
  localparam int AST_BYTE_ORDER = 2;
  localparam int AST_QUARTER = 3;
  localparam int AST_TEST = 7;
  localparam logic [7:0] AST_WMASK = 8'h8c;
  // host_buffer_mode_control fields
  localparam logic [7:0] HBM_WMASK = 8'h1f;
  // link rates
  localparam longint CLOCK_HZ = 64'd10000000;
  localparam longint RATE_00_BAUD = 64'd31250;
  localparam longint RATE_01_BAUD = 64'd62500;
  localparam longint RATE_10_BAUD = 64'd187500;
  localparam logic [8:0] RATE_00_CYCLES = 9'(CLOCK_HZ / RATE_00_BAUD);
  localparam logic [8:0] RATE_01_CYCLES = 9'(CLOCK_HZ / RATE_01_BAUD);
  localparam logic [8:0] RATE_10_CYCLES = 9'(CLOCK_HZ / RATE_10_BAUD);
  localparam logic [1:0] RATE_NONE = 2'h3;
  // serial clock synthesis
  localparam longint REF_HZ = 64'd16945000;
  localparam int FRAC_BITS = 12;
  localparam logic [17:0] REF_STEP =
    18'((REF_HZ << FRAC_BITS) / CLOCK_HZ);
  localparam logic [6:0] DIV_SPAN = 7'h40;
  localparam logic [5:0] DIV_MAX = 6'h3a;
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  typedef struct packed {
    logic read;
    logic write;
    logic [15:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avl_req_type;

  typedef struct packed {
    logic offset_usage;
    logic end_offset_bank_select;
    logic start_offset_bank_select;
    logic transfer_direction;
    logic buffer_access_granularity;
  } host_mode_type;
endpackage

// ==== rtl/misc_ctrl.sv ====
// Purpose: misc serial, audio, test and host buffer control bank
// Assumes: Avalon-MM slave, word indices as addresses
// Notes: lock, external clock and test pins pass two flops before use
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - rate field picks link bit period; code 11 gives no bit tick.
// - q_channel_invert set inverts every captured Q-channel bit.
// - subchannel_invert set inverts every captured sub-code bit.
// - even_parity_select set gives even parity, clear gives odd.
// - lock flag reads synthesizer stable state; writes to it ignored.
// - software sets doubler bit after lock; bit then engages doubler.
// - serial clock comes from programmable count of 16.945 MHz reference.
// - divisor 0 gives 0.264 MHz, 58 gives 2.82 MHz, the maximum.
// - sampling select 0 samples with external clock, 1 internal clock.
// - source select 0 uses pin, internal off; 1 uses internal counter.
// - audio bytes swapped in audio mode unless audio_byte_order_disable set.
// - quarter_rate_sampling makes sub-code sample every fourth tick.
// - test bit with test pin high routes internal signals out.
// - host buffer mode fields drive DRAM control directly and at once.
// - buffer_access_granularity 0 byte mode, 1 page mode.
// - direction 0 reads buffer memory, 1 writes buffer memory.
// - start_offset_bank_select 0 picks A set, 1 picks B set.
// - end offset bank select 0 picks A set, 1 picks B set.
// - offset usage 0 uses only A registers, 1 uses A and B.
module misc_ctrl
  import misc_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire avl_req_type avl_req,
  output logic waitrequest,
  output logic [31:0] readdata,
  input wire logic synth_lock,
  input wire logic ext_uart_clock,
  input wire logic test_pin,
  input wire logic [7:0] q_raw,
  input wire logic [7:0] subcode_raw,
  input wire logic [7:0] link_tx_byte,
  input wire logic audio_mode,
  input wire logic [15:0] audio_word,
  input wire logic subcode_sample_tick,
  output logic link_bit_tick,
  output logic link_parity,
  output logic [7:0] q_data,
  output logic [7:0] subcode_data,
  output logic doubler_engage,
  output logic uart_clock,
  output logic uart_sample_clock,
  output logic [15:0] audio_store_word,
  output logic subcode_sample_enable,
  output logic [3:0] test_out,
  output host_mode_type host_buffer_mode
);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [7:0] bpc_reg;
  logic [7:0] scd_reg;
  logic [7:0] ast_reg;
  logic [4:0] hbm_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [8:0] baud_cnt_reg;
  logic link_bit_tick_reg;
  logic link_parity_reg;
  logic [7:0] q_data_reg;
  logic [7:0] subcode_data_reg;
  logic doubler_engage_reg;
  logic [17:0] acc_reg;
  logic int_clk_reg;
  logic uart_clock_reg;
  logic uart_sample_clock_reg;
  logic [15:0] audio_store_word_reg;
  logic [1:0] quarter_cnt_reg;
  logic subcode_sample_enable_reg;
  logic [3:0] test_out_reg;

  logic req;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [7:0] read_mux;
  logic lock_sync;
  logic ext_clk_sync;
  logic test_sync;
  logic [8:0] baud_limit;
  logic [5:0] div_eff;
  logic [6:0] span;
  logic [17:0] half_span;
  logic [17:0] acc_sum;

  ////////////////////////////////////////////////////////////////////
  // bus slave

  assign req = avl_req.read | avl_req.write;
  assign wr_fire = avl_req.write & ~waitrequest_reg &
    avl_req.byteenable[0];
  assign wbyte = avl_req.writedata[7:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= ~(req & waitrequest_reg);
    end
  end

  always_comb begin
    read_mux = 8'h00;
    if (avl_req.address == BAUD_PARITY_CLOCK_CONTROL_IDX) begin
      read_mux = bpc_reg & BPC_WMASK;
      read_mux[BPC_LOCK] = lock_sync;
    end else if (avl_req.address == SERIAL_CLOCK_DIVIDER_CONTROL_IDX)
    begin
      read_mux = scd_reg;
    end else if (avl_req.address == AUDIO_SWAP_TEST_CONTROL_IDX) begin
      read_mux = ast_reg & AST_WMASK;
    end else if (avl_req.address == HOST_BUFFER_MODE_CONTROL_IDX) begin
      read_mux = {3'h0, hbm_reg};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avl_req.read & waitrequest_reg) begin
      readdata_reg <= {24'h00_0000, read_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bpc_reg <= CTRL_RESET;
      scd_reg <= CTRL_RESET;
      ast_reg <= CTRL_RESET;
      hbm_reg <= CTRL_RESET[4:0];
    end else if (wr_fire) begin
      if (avl_req.address == BAUD_PARITY_CLOCK_CONTROL_IDX) begin
        bpc_reg <= wbyte & BPC_WMASK;
      end else if (avl_req.address == SERIAL_CLOCK_DIVIDER_CONTROL_IDX)
      begin
        scd_reg <= wbyte & SCD_WMASK;
      end else if (avl_req.address == AUDIO_SWAP_TEST_CONTROL_IDX) begin
        ast_reg <= wbyte & AST_WMASK;
      end else if (avl_req.address == HOST_BUFFER_MODE_CONTROL_IDX) begin
        hbm_reg <= wbyte[4:0] & HBM_WMASK[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {test_pin, ext_uart_clock, synth_lock};
      sync2_reg <= sync1_reg;
    end
  end

  assign lock_sync = sync2_reg[0];
  assign ext_clk_sync = sync2_reg[1];
  assign test_sync = sync2_reg[2];

  ////////////////////////////////////////////////////////////////////
  // sub-code serial link

  always_comb begin
    case (bpc_reg[BPC_RATE_LSB +: 2])
      2'h0: baud_limit = RATE_00_CYCLES;
      2'h1: baud_limit = RATE_01_CYCLES;
      2'h2: baud_limit = RATE_10_CYCLES;
      default: baud_limit = 9'h000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      baud_cnt_reg <= 9'h000;
      link_bit_tick_reg <= 1'b0;
    end else if (bpc_reg[BPC_RATE_LSB +: 2] == RATE_NONE) begin
      baud_cnt_reg <= 9'h000;
      link_bit_tick_reg <= 1'b0;
    end else if (baud_cnt_reg >= baud_limit - 9'h001) begin
      baud_cnt_reg <= 9'h000;
      link_bit_tick_reg <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 9'h001;
      link_bit_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_parity_reg <= 1'b0;
      q_data_reg <= 8'h00;
      subcode_data_reg <= 8'h00;
    end else begin
      link_parity_reg <= bpc_reg[BPC_EVEN] ? ^link_tx_byte :
        ~^link_tx_byte;
      q_data_reg <= q_raw ^ {8{bpc_reg[BPC_Q_INV]}};
      subcode_data_reg <= subcode_raw ^ {8{bpc_reg[BPC_SUB_INV]}};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      doubler_engage_reg <= 1'b0;
    end else begin
      doubler_engage_reg <= bpc_reg[BPC_DOUBLER] & lock_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // serial clock synthesis

  assign div_eff = (scd_reg[SCD_DIV_LSB +: 6] > DIV_MAX) ? DIV_MAX :
    scd_reg[SCD_DIV_LSB +: 6];
  assign span = DIV_SPAN - {1'b0, div_eff};
  assign half_span = {span, 11'h000};
  assign acc_sum = acc_reg + REF_STEP;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_reg <= 18'h00000;
      int_clk_reg <= 1'b0;
    end else if (!scd_reg[SCD_SOURCE]) begin
      acc_reg <= 18'h00000;
      int_clk_reg <= 1'b0;
    end else if (acc_sum >= half_span) begin
      acc_reg <= acc_sum - half_span;
      int_clk_reg <= ~int_clk_reg;
    end else begin
      acc_reg <= acc_sum;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      uart_clock_reg <= 1'b0;
      uart_sample_clock_reg <= 1'b0;
    end else begin
      uart_clock_reg <= scd_reg[SCD_SOURCE] ? int_clk_reg :
        ext_clk_sync;
      uart_sample_clock_reg <= scd_reg[SCD_SAMPLING] ? int_clk_reg :
        ext_clk_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // audio swap, quarter rate, test mux

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      audio_store_word_reg <= 16'h0000;
    end else if (audio_mode & ~ast_reg[AST_BYTE_ORDER]) begin
      audio_store_word_reg <= {audio_word[7:0], audio_word[15:8]};
    end else begin
      audio_store_word_reg <= audio_word;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      quarter_cnt_reg <= 2'h0;
      subcode_sample_enable_reg <= 1'b0;
    end else begin
      if (subcode_sample_tick) begin
        quarter_cnt_reg <= quarter_cnt_reg + 2'h1;
      end
      subcode_sample_enable_reg <= subcode_sample_tick &
        (~ast_reg[AST_QUARTER] | quarter_cnt_reg == QUARTER_LAST);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      test_out_reg <= 4'h0;
    end else if (ast_reg[AST_TEST] & test_sync) begin
      test_out_reg <= {doubler_engage_reg, int_clk_reg,
        link_bit_tick_reg, lock_sync};
    end else begin
      test_out_reg <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign waitrequest = waitrequest_reg;
  assign readdata = readdata_reg;
  assign link_bit_tick = link_bit_tick_reg;
  assign link_parity = link_parity_reg;
  assign q_data = q_data_reg;
  assign subcode_data = subcode_data_reg;
  assign doubler_engage = doubler_engage_reg;
  assign uart_clock = uart_clock_reg;
  assign uart_sample_clock = uart_sample_clock_reg;
  assign audio_store_word = audio_store_word_reg;
  assign subcode_sample_enable = subcode_sample_enable_reg;
  assign test_out = test_out_reg;
  assign host_buffer_mode = hbm_reg;

  ////////////////////////////////////////////////////////////////////
  // checks

  a_rate_none_quiet: assert property (
    bpc_reg[1:0] == RATE_NONE |=> !link_bit_tick_reg)
    else $error("bit tick with undefined rate");

  a_q_invert: assert property (
    ##1 q_data_reg == ($past(q_raw) ^ {8{$past(bpc_reg[BPC_Q_INV])}}))
    else $error("q data inversion wrong");

  a_sub_invert: assert property (
    ##1 subcode_data_reg ==
      ($past(subcode_raw) ^ {8{$past(bpc_reg[BPC_SUB_INV])}}))
    else $error("sub-code inversion wrong");

  a_parity_total: assert property (
    !rst |=> (^{$past(link_tx_byte), link_parity_reg}) ==
      !$past(bpc_reg[BPC_EVEN]))
    else $error("parity sense wrong");

  a_lock_readback: assert property (
    avl_req.read && waitrequest_reg &&
    avl_req.address == BAUD_PARITY_CLOCK_CONTROL_IDX
    |=> readdata_reg[BPC_LOCK] == $past(lock_sync) && !bpc_reg[BPC_LOCK])
    else $error("lock flag readback wrong");

  a_doubler_gate: assert property (
    doubler_engage_reg |-> $past(lock_sync) && $past(bpc_reg[7]))
    else $error("doubler engaged without cause");

  a_int_clk_off: assert property (
    !scd_reg[SCD_SOURCE] |=> !int_clk_reg && uart_clock_reg ==
      $past(ext_clk_sync))
    else $error("internal clock not disabled");

  a_sample_select: assert property (
    ##1 uart_sample_clock_reg == ($past(scd_reg[SCD_SAMPLING]) ?
      $past(int_clk_reg) : $past(ext_clk_sync)))
    else $error("sample clock source wrong");

  a_audio_swap: assert property (
    audio_mode && !ast_reg[AST_BYTE_ORDER] |=>
      audio_store_word_reg[7:0] == $past(audio_word[15:8]))
    else $error("audio bytes not swapped");

  a_quarter_rate: assert property (
    subcode_sample_enable_reg && ast_reg[AST_QUARTER] &&
    $stable(ast_reg) |=> (!subcode_sample_enable_reg)[*3])
    else $error("quarter rate sampling too fast");

  a_test_gate: assert property (
    !test_sync || !ast_reg[AST_TEST] |=> test_out_reg == 4'h0)
    else $error("test mux open without enable");

  a_mode_now: assert property (
    wr_fire && avl_req.address == HOST_BUFFER_MODE_CONTROL_IDX
    |=> host_buffer_mode == $past(wbyte[4:0]))
    else $error("host mode write not immediate");

  a_unused_zero: assert property (
    ##1 readdata_reg[31:8] == 24'h00_0000 && !ast_reg[6] &&
      !ast_reg[1] && !bpc_reg[2])
    else $error("unused bits not zero");

endmodule

// ==== verif/misc_far_side.sv ====
// Purpose: far side model, synthesizer lock pin and external uart clock
// Assumes: lock settles a fixed time after reset
// Notes: external clock free runs like a crystal source
`timescale 1ns/1ps
module misc_far_side
  import misc_ctrl_pkg::*;
#(
  parameter int LOCK_DELAY = 300,
  parameter int EXT_HALF = 3
) (
  input wire logic clock,
  input wire logic rst,
  output logic synth_lock,
  output logic ext_uart_clock
);
  int lock_cnt;
  int half_cnt;
  ////////////////////////////////////////////////////////////////////////
  // lock rises once the synthesizer has settled after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_cnt <= 0;
      synth_lock <= 1'b0;
    end else if (lock_cnt < LOCK_DELAY) begin
      lock_cnt <= lock_cnt + 1;
    end else begin
      synth_lock <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // external uart clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      half_cnt <= 0;
      ext_uart_clock <= 1'b0;
    end else if (half_cnt == EXT_HALF - 1) begin
      half_cnt <= 0;
      ext_uart_clock <= ~ext_uart_clock;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end
endmodule

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the misc control bank
// Assumes: one wait state per bus access, seed fixed
// Notes: expectations come from bench functions
`timescale 1ns/1ps
module tb
  import misc_ctrl_pkg::*;
;
  logic clock, rst, ext_uart_clock, synth_lock, test_pin, audio_mode;
  logic subcode_sample_tick, waitrequest, link_bit_tick, link_parity;
  logic doubler_engage, uart_clock, uart_sample_clock;
  logic subcode_sample_enable, uc_q, sc_q;
  logic [7:0] q_raw, subcode_raw, link_tx_byte, q_data, subcode_data, r;
  logic [15:0] audio_word, audio_store_word;
  logic [31:0] readdata;
  logic [3:0] test_out;
  avl_req_type avl_req;
  host_mode_type host_buffer_mode;
  int miscompares, num_checks, seed, en_cnt, uc_edges, sc_edges, n, s;
  logic [15:0] addrs [4];
  logic [7:0] masks [4];
  logic [31:0] v;
  misc_ctrl misc_ctrl_inst (.clock(clock), .rst(rst), .avl_req(avl_req),
    .waitrequest(waitrequest), .readdata(readdata),
    .synth_lock(synth_lock), .ext_uart_clock(ext_uart_clock),
    .test_pin(test_pin), .q_raw(q_raw), .subcode_raw(subcode_raw),
    .link_tx_byte(link_tx_byte), .audio_mode(audio_mode),
    .audio_word(audio_word), .subcode_sample_tick(subcode_sample_tick),
    .link_bit_tick(link_bit_tick), .link_parity(link_parity),
    .q_data(q_data), .subcode_data(subcode_data),
    .doubler_engage(doubler_engage), .uart_clock(uart_clock),
    .uart_sample_clock(uart_sample_clock),
    .audio_store_word(audio_store_word),
    .subcode_sample_enable(subcode_sample_enable), .test_out(test_out),
    .host_buffer_mode(host_buffer_mode));
  misc_far_side misc_far_side_inst (.clock(clock), .rst(rst),
    .synth_lock(synth_lock), .ext_uart_clock(ext_uart_clock));
  ////////////////////////////////////////////////////////////////////////
  // clock, edge counters, watchdog
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    if (subcode_sample_enable === 1'b1) en_cnt++;
    if (uart_clock === 1'b1 && uc_q === 1'b0) uc_edges++;
    if (uart_sample_clock === 1'b1 && sc_q === 1'b0) sc_edges++;
    uc_q = uart_clock;
    sc_q = uart_sample_clock;
  end
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////
  // tasks and functions
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic near(input string nm, input int e, input int g);
    num_checks++;
    if (g > e + 2 || g < e - 2) begin
      miscompares++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge clock);
    avl_req <= '{read: !w, write: w, address: a,
                 writedata: {24'h0, d}, byteenable: be};
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      miscompares++;
      end_sim();
    end else begin
      r = readdata[7:0];
      avl_req <= '0;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  function automatic int rate_cycles(input logic [1:0] c);
    return c == 2'h0 ? 320 : c == 2'h1 ? 160 : c == 2'h2 ? 53 : 0;
  endfunction
  function automatic int uart_edges(input int d, input int cyc);
    return int'(16945000.0 * cyc / ((64 - d) * 1.0e7));
  endfunction
  function automatic logic [15:0] stored(input logic m, input logic dis,
                                         input logic [15:0] w);
    return (m && !dis) ? {w[7:0], w[15:8]} : w;
  endfunction
  task automatic span(input int cyc);
    n = uc_edges;
    s = sc_edges;
    repeat (cyc) @(posedge clock);
    n = uc_edges - n;
    s = sc_edges - s;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 53899;
    miscompares = 0;
    num_checks = 0;
    {en_cnt, uc_edges, sc_edges} = '0;
    {uc_q, sc_q, test_pin, audio_mode, subcode_sample_tick} = '0;
    {q_raw, subcode_raw, link_tx_byte, audio_word} = '0;
    avl_req = '0;
    addrs = '{SERIAL_CLOCK_DIVIDER_CONTROL_IDX, BAUD_PARITY_CLOCK_CONTROL_IDX,
      AUDIO_SWAP_TEST_CONTROL_IDX, HOST_BUFFER_MODE_CONTROL_IDX};
    masks = '{SCD_WMASK, BPC_WMASK, AST_WMASK, HBM_WMASK};
    rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, addrs[i], 8'h0, 4'h1);
      chk("reset value", 32'h0, {24'h0, r});
    end
    wr(16'h0000, 8'hff);
    bus(1'b0, 16'h0000, 8'h0, 4'h1);
    chk("unmapped", 32'h0, {24'h0, r});
    bus(1'b1, addrs[3], 8'h1f, 4'h0);
    bus(1'b0, addrs[3], 8'h0, 4'h1);
    chk("byteenable off", 32'h0, {24'h0, r});
    n = 0;
    while (synth_lock !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    chk("lock seen", 32'h1, {31'h0, synth_lock});
    repeat (4) @(posedge clock);
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      wr(addrs[v[9:8]], v[7:0]);
      bus(1'b0, addrs[v[9:8]], 8'h0, 4'h1);
      chk("readback", {24'h0, (v[7:0] & masks[v[9:8]]) |
          ((v[9:8] == 2'h1) ? 8'h40 : 8'h00)}, {24'h0, r});
    end
    for (int i = 0; i < 13; i++) begin
      v = (i < 5) ? (32'h1 << i) : $random(seed);
      wr(addrs[3], v[7:0]);
      @(posedge clock);
      chk("host mode", v[4:0], host_buffer_mode);
    end
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(addrs[1], {2'h0, v[5:3], 3'h0});
      q_raw <= v[15:8];
      subcode_raw <= v[23:16];
      link_tx_byte <= v[31:24];
      repeat (2) @(posedge clock);
      chk("q_data", v[15:8] ^ {8{v[3]}}, q_data);
      chk("subcode_data", v[23:16] ^ {8{v[4]}}, subcode_data);
      chk("parity", v[5] ? ^v[31:24] : ~^v[31:24], link_parity);
    end
    for (int c = 0; c < 4; c++) begin
      wr(addrs[1], 8'(c));
      repeat (2) @(posedge clock);
      n = 0;
      while (link_bit_tick !== 1'b1 && n < 700) begin
        @(posedge clock);
        n++;
      end
      if (n < 700) begin
        n = 0;
        do begin
          @(posedge clock);
          n++;
        end while (link_bit_tick !== 1'b1 && n < 700);
      end
      chk("bit period", rate_cycles(2'(c)), (n >= 700) ? 0 : n);
    end
    wr(addrs[1], 8'h80);
    repeat (3) @(posedge clock);
    chk("doubler on", 32'h1, doubler_engage);
    wr(addrs[1], 8'h00);
    repeat (3) @(posedge clock);
    chk("doubler off", 32'h0, doubler_engage);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(addrs[2], {5'h0, i[1], 2'h0});
      audio_mode <= i[0];
      audio_word <= v[15:0];
      repeat (2) @(posedge clock);
      chk("audio word", stored(i[0], i[1], v[15:0]), audio_store_word);
    end
    for (int i = 0; i < 2; i++) begin
      wr(addrs[2], {4'h0, i[0], 3'h0});
      s = en_cnt;
      repeat (16) begin
        @(posedge clock);
        subcode_sample_tick <= 1'b1;
        @(posedge clock);
        subcode_sample_tick <= 1'b0;
      end
      repeat (3) @(posedge clock);
      chk("sample enables", i ? 4 : 16, en_cnt - s);
    end
    wr(addrs[0], 8'h40);
    repeat (4) @(posedge clock);
    span(200);
    chk("internal off", 32'h0, s);
    near("pin clock", 33, n);
    wr(addrs[0], 8'h00);
    span(200);
    near("pin sampling", 33, s);
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 15 : 58;
      wr(addrs[0], 8'hc0 | 8'(n));
      repeat (10) @(posedge clock);
      v = n;
      span(2000);
      near("internal clock", uart_edges(v, 2000), n);
      near("internal sampling", uart_edges(v, 2000), s);
    end
    wr(addrs[2], 8'h80);
    test_pin <= 1'b1;
    repeat (5) @(posedge clock);
    chk("test lock", 32'h1, test_out[0]);
    test_pin <= 1'b0;
    repeat (5) @(posedge clock);
    chk("test pin low", 32'h0, test_out);
    wr(addrs[2], 8'h00);
    test_pin <= 1'b1;
    repeat (5) @(posedge clock);
    chk("test bit low", 32'h0, test_out);
    end_sim();
  end
endmodule
